//--- verif/b2s_properties.sv
// Timing checks on the link between memory master and memory device
`timescale 1ns/1ps
module b2s_properties
  import b2s_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic k_phase,
  input wire logic k_run,
  input wire logic dll_enable,
  input wire logic load_strobe_n,
  input wire logic read_sel,
  input wire logic host_dq_oe,
  input wire logic dev_dq_oe
);
  logic rd_cmd;
  logic wr_cmd;
  // Command seen by the device at a K rise
  assign rd_cmd = k_phase && k_run && !load_strobe_n && read_sel;
  assign wr_cmd = k_phase && k_run && !load_strobe_n && !read_sel;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  property p_strobe_on_k;
    !load_strobe_n |-> k_phase && k_run;
  endproperty
  a_strobe_on_k: assert property (p_strobe_on_k)
    else $error("load strobe active off a K rise");
  property p_rd_start;
    $rose(dev_dq_oe) |->
      (dll_enable ? $past(rd_cmd, 4) : $past(rd_cmd, 3));
  endproperty
  a_rd_start: assert property (p_rd_start)
    else $error("read data driven at wrong distance from command");
  property p_rd_two;
    $rose(dev_dq_oe) |=> dev_dq_oe ##1 !dev_dq_oe;
  endproperty
  a_rd_two: assert property (p_rd_two)
    else $error("read burst not exactly two beats");
  property p_wr_start;
    $rose(host_dq_oe) |-> $past(wr_cmd, 8) && k_phase;
  endproperty
  a_wr_start: assert property (p_wr_start)
    else $error("write data driven at wrong distance from command");
  property p_wr_two;
    $rose(host_dq_oe) |=> host_dq_oe ##1 !host_dq_oe;
  endproperty
  a_wr_two: assert property (p_wr_two)
    else $error("write burst not exactly two beats");
  property p_no_clash;
    !(dev_dq_oe && host_dq_oe);
  endproperty
  a_no_clash: assert property (p_no_clash)
    else $error("both ends drive the data bus");
  property p_idle_bus;
    load_strobe_n [*8] ##1 load_strobe_n [*4] |->
      !dev_dq_oe && !host_dq_oe;
  endproperty
  a_idle_bus: assert property (p_idle_bus)
    else $error("data bus driven with no command pending");
  property p_stop_quiet;
    !k_run |-> load_strobe_n && !dev_dq_oe && !host_dq_oe;
  endproperty
  a_stop_quiet: assert property (p_stop_quiet)
    else $error("activity while clocks stopped");
  property p_stop_frozen;
    !k_run && !$past(k_run) |-> $stable(k_phase);
  endproperty
  a_stop_frozen: assert property (p_stop_frozen)
    else $error("K phase moved while clocks stopped");
endmodule // b2s_properties

//--- verif/burst2_common_io_sram_port_test.sv
// Self-checking bench for the two-word burst memory port
`timescale 1ns/1ps
module burst2_common_io_sram_port_test;
  import b2s_pkg::*;
  localparam logic [DQ_W-1:0] ONES = 36'hfffffffff;
  localparam logic [DQ_W-1:0] D0 = 36'h123456789;
  localparam logic [DQ_W-1:0] D1 = 36'h0abcdef01;
  logic ref_clk, sys_rst, clk_en, wide_org_strap, dll_enable_in;
  logic single_clock, stop_req, cmd_valid, cmd_ready, cmd_write;
  logic rd_valid, rd_ready, stopped, dll_locked, org_wide, kp;
  logic [ADDR_W-1:0] cmd_addr;
  logic [DQ_W-1:0] wr_data0, wr_data1, exp0, exp1;
  logic [LANES-1:0] wr_be0_n, wr_be1_n;
  logic [BUF_W-1:0] rd_data;
  int bad_count, cmp_count;
  b2s_if b2s_if_i();
  b2s_host b2s_host_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .clk_en(clk_en), .dll_enable_in(dll_enable_in),
    .single_clock(single_clock), .stop_req(stop_req),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write),
    .cmd_addr(cmd_addr), .wr_data0(wr_data0), .wr_data1(wr_data1),
    .wr_be0_n(wr_be0_n), .wr_be1_n(wr_be1_n), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .rd_data(rd_data), .stopped(stopped),
    .link(b2s_if_i));
  b2s_device b2s_device_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .clk_en(clk_en), .wide_org_strap(wide_org_strap), .link(b2s_if_i),
    .dll_locked(dll_locked), .org_wide(org_wide));
  b2s_properties b2s_properties_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .k_phase(b2s_if_i.k_phase), .k_run(b2s_if_i.k_run),
    .dll_enable(b2s_if_i.dll_enable),
    .load_strobe_n(b2s_if_i.load_strobe_n),
    .read_sel(b2s_if_i.read_sel), .host_dq_oe(b2s_if_i.host_dq_oe),
    .dev_dq_oe(b2s_if_i.dev_dq_oe));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic check(input string name, input logic [BUF_W-1:0] seen,
                       input logic [BUF_W-1:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic issue(input logic w, input logic [ADDR_W-1:0] a);
    int n;
    n = 0;
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_addr = a;
    while (cmd_ready !== 1'b1 && n < 6000) begin
      tick(1);
      n++;
    end
    check("cmd_ready", cmd_ready, 1'b1);
    tick(1);
    cmd_valid = 1'b0;
    tick(1);
  endtask
  task automatic write(input logic [ADDR_W-1:0] a,
                       input logic [DQ_W-1:0] d0, d1,
                       input logic [LANES-1:0] b0, b1);
    wr_data0 = d0;
    wr_data1 = d1;
    wr_be0_n = b0;
    wr_be1_n = b1;
    issue(1'b1, a);
  endtask
  task automatic pop(input logic [BUF_W-1:0] exp);
    int n;
    n = 0;
    while (rd_valid !== 1'b1 && n < 50) begin
      tick(1);
      n++;
    end
    check("rd_data", rd_data, exp);
    rd_ready = 1'b1;
    tick(1);
    rd_ready = 1'b0;
    tick(1);
  endtask
  task automatic read(input logic [ADDR_W-1:0] a,
                      input logic [BUF_W-1:0] exp);
    issue(1'b0, a);
    pop(exp);
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge ref_clk);
    bad_count++;
    final_report();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    {sys_rst, clk_en, wide_org_strap} = 3'h7;
    {dll_enable_in, single_clock, stop_req} = 3'h0;
    {cmd_valid, cmd_write, rd_ready} = 3'h0;
    cmd_addr = '0;
    wr_data0 = '0;
    wr_data1 = '0;
    wr_be0_n = BE_NONE;
    wr_be1_n = BE_NONE;
    bad_count = 0;
    cmp_count = 0;
    tick(5);
    check("idle strobe", b2s_if_i.load_strobe_n, 1'b1);
    check("org_wide", org_wide, 1'b1);
    sys_rst = 1'b0;
    write(19'h00010, D0, D1, 4'h0, 4'h0);
    read(19'h00010, {D1, D0});
    read(19'h00011, {D0, D1});
    for (int i = 0; i < LANES; i++) begin
      write(19'h00020, ONES, ONES, 4'h0, 4'h0);
      write(19'h00020, '0, '0, ~(4'h1 << i), BE_NONE);
      exp0 = ONES;
      exp0[i*LANE_W +: LANE_W] = '0;
      read(19'h00020, {ONES, exp0});
    end
    // Fill the read buffer, see a read refused, then drain it
    issue(1'b0, 19'h00010);
    issue(1'b0, 19'h00011);
    cmd_valid = 1'b1;
    tick(20);
    check("full refuse", cmd_ready, 1'b0);
    cmd_valid = 1'b0;
    pop({D1, D0});
    pop({D0, D1});
    tick(2);
    check("empty", rd_valid, 1'b0);
    kp = b2s_if_i.k_phase;
    clk_en = 1'b0;
    tick(10);
    check("frozen k", b2s_if_i.k_phase, kp);
    clk_en = 1'b1;
    stop_req = 1'b1;
    for (int n = 0; n < 50 && stopped !== 1'b1; n++) tick(1);
    tick(8);
    check("stopped", stopped, 1'b1);
    check("stop refuse", cmd_ready, 1'b0);
    stop_req = 1'b0;
    read(19'h00010, {D1, D0});
    dll_enable_in = 1'b1;
    tick(2);
    check("relock", dll_locked, 1'b0);
    read(19'h00010, {D1, D0});
    check("locked", dll_locked, 1'b1);
    single_clock = 1'b1;
    read(19'h00011, {D0, D1});
    single_clock = 1'b0;
    dll_enable_in = 1'b0;
    wide_org_strap = 1'b0;
    sys_rst = 1'b1;
    tick(5);
    sys_rst = 1'b0;
    check("org_narrow", org_wide, 1'b0);
    write(19'h00010, '0, '0, 4'h0, 4'hd);
    exp0 = D0;
    exp0[17:0] = '0;
    exp1 = D1;
    exp1[17:9] = '0;
    read(19'h00010, {exp1, exp0});
    final_report();
  end
endmodule // burst2_common_io_sram_port_test

//--- verilog/b2s_device.sv
// Memory device end: command pipeline, burst array, loop lock model
`timescale 1ns/1ps
module b2s_device
  import b2s_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic wide_org_strap,
  b2s_if.dev link,
  output logic dll_locked,
  output logic org_wide
);
  logic [DQ_W-1:0] mem [MEM_WORDS];
  logic op_v_reg [PIPE_LEN];
  logic op_v_next [PIPE_LEN];
  logic op_w_reg [PIPE_LEN];
  logic op_w_next [PIPE_LEN];
  logic [ADDR_W-1:0] op_a_reg [PIPE_LEN];
  logic [ADDR_W-1:0] op_a_next [PIPE_LEN];
  logic [DQ_W-1:0] dq_reg, dq_next;
  logic dq_oe_reg, dq_oe_next;
  logic wide_reg, wide_next;
  logic strap_sync_reg;
  logic [STOP_W-1:0] stop_cnt_reg, stop_cnt_next;
  logic [LOCK_W-1:0] lock_cnt_reg, lock_cnt_next;
  logic locked_reg, locked_next;
  logic dll_en_reg, dll_en_next;
  logic adv, out_ok, mem_we;
  logic [ADDR_W-1:0] mem_wa;
  logic [DQ_W-1:0] mem_wd;
  int lat;

  // ----------------------------------------------------------------
  // Command pipeline
  // ----------------------------------------------------------------
  assign adv = clk_en & link.k_run;
  assign out_ok = link.c_tied_high | link.k_run;
  assign lat = link.dll_enable ? RD_LAT_DLL : RD_LAT_BYP;

  always_comb begin
    for (int i = 0; i < PIPE_LEN; i++) begin
      op_v_next[i] = op_v_reg[i];
      op_w_next[i] = op_w_reg[i];
      op_a_next[i] = op_a_reg[i];
    end
    if (adv) begin
      for (int i = 1; i < PIPE_LEN; i++) begin
        op_v_next[i] = op_v_reg[i-1];
        op_w_next[i] = op_w_reg[i-1];
        op_a_next[i] = op_a_reg[i-1];
      end
      // Command valid only at a K rise; address and read_sel registered every cycle the pipeline advances
      op_v_next[0] = link.k_phase & ~link.load_strobe_n;
      op_w_next[0] = ~link.read_sel;
      op_a_next[0] = link.addr;
    end
  end

  // ----------------------------------------------------------------
  // Read drive and write capture
  // ----------------------------------------------------------------
  always_comb begin
    dq_next = dq_reg;
    dq_oe_next = dq_oe_reg;
    mem_we = 1'b0;
    mem_wa = op_a_reg[WR_LAT-1];
    mem_wd = DQ_RST;
    if (adv) begin
      dq_oe_next = 1'b0;
      if (out_ok && op_v_reg[lat-1] && !op_w_reg[lat-1]) begin
        dq_next = mem[op_a_reg[lat-1]];
        dq_oe_next = 1'b1;
      end else if (out_ok && op_v_reg[lat] && !op_w_reg[lat]) begin
        dq_next = mem[op_a_reg[lat] ^ 19'h00001];
        dq_oe_next = 1'b1;
      end
      if (op_v_reg[WR_LAT-1] && op_w_reg[WR_LAT-1]) begin
        mem_we = 1'b1;
        mem_wa = op_a_reg[WR_LAT-1];
      end else if (op_v_reg[WR_LAT] && op_w_reg[WR_LAT]) begin
        mem_we = 1'b1;
        mem_wa = op_a_reg[WR_LAT] ^ 19'h00001;
      end
      mem_wd = mem[mem_wa];
      for (int l = 0; l < LANES; l++) begin
        // Narrow parts ignore the upper two lane enables
        if (!link.byte_enable_n[l] && (wide_reg || l < NARROW_LANES)) begin
          mem_wd[l*LANE_W +: LANE_W] = link.dq[l*LANE_W +: LANE_W];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Loop lock model
  // ----------------------------------------------------------------
  always_comb begin
    wide_next = wide_reg;
    stop_cnt_next = stop_cnt_reg;
    lock_cnt_next = lock_cnt_reg;
    locked_next = locked_reg;
    dll_en_next = dll_en_reg;
    if (clk_en) begin
      dll_en_next = link.dll_enable;
      if (link.k_run) begin
        stop_cnt_next = '0;
        if (link.k_phase && lock_cnt_reg != LOCK_W'(DLL_LOCK_KCYC)) begin
          lock_cnt_next = lock_cnt_reg + 1'b1;
        end
      end else if (stop_cnt_reg != STOP_W'(DLL_STOP_CYC)) begin
        stop_cnt_next = stop_cnt_reg + 1'b1;
      end
      if (stop_cnt_next == STOP_W'(DLL_STOP_CYC) ||
          (link.dll_enable && !dll_en_reg)) begin
        lock_cnt_next = '0;
      end
      locked_next = !link.dll_enable ||
                    lock_cnt_next == LOCK_W'(DLL_LOCK_KCYC);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < PIPE_LEN; i++) begin
        op_v_reg[i] <= 1'b0;
        op_w_reg[i] <= 1'b0;
        op_a_reg[i] <= ADDR_RST;
      end
      dq_reg <= DQ_RST;
      dq_oe_reg <= 1'b0;
      // Strap pin passes two flops before use
      strap_sync_reg <= wide_org_strap;
      wide_reg <= strap_sync_reg;
      stop_cnt_reg <= '0;
      lock_cnt_reg <= '0;
      locked_reg <= 1'b0;
      dll_en_reg <= 1'b0;
    end else begin
      for (int i = 0; i < PIPE_LEN; i++) begin
        op_v_reg[i] <= op_v_next[i];
        op_w_reg[i] <= op_w_next[i];
        op_a_reg[i] <= op_a_next[i];
      end
      dq_reg <= dq_next;
      dq_oe_reg <= dq_oe_next;
      strap_sync_reg <= wide_org_strap;
      wide_reg <= wide_next;
      stop_cnt_reg <= stop_cnt_next;
      lock_cnt_reg <= lock_cnt_next;
      locked_reg <= locked_next;
      dll_en_reg <= dll_en_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (mem_we && !sys_rst) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  assign link.dev_dq = dq_reg;
  assign link.dev_dq_oe = dq_oe_reg;
  assign dll_locked = locked_reg;
  assign org_wide = wide_reg;
endmodule // b2s_device

//--- verilog/b2s_host.sv
// Master end: K generation, command issue, write drive, read buffer
`timescale 1ns/1ps
module b2s_host
  import b2s_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic dll_enable_in,
  input wire logic single_clock,
  input wire logic stop_req,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_write,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [DQ_W-1:0] wr_data0,
  input wire logic [DQ_W-1:0] wr_data1,
  input wire logic [LANES-1:0] wr_be0_n,
  input wire logic [LANES-1:0] wr_be1_n,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [BUF_W-1:0] rd_data,
  output logic stopped,
  b2s_if.host link
);
  b2s_state_t st_reg, st_next;
  logic kp_reg, kp_next, run_reg, run_next;
  logic ld_n_reg, ld_n_next, rsel_reg, rsel_next;
  logic [ADDR_W-1:0] a_reg, a_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [DQ_W-1:0] wd0_reg, wd0_next, wd1_reg, wd1_next;
  logic [LANES-1:0] be0_reg, be0_next, be1_reg, be1_next;
  logic [DQ_W-1:0] dq_reg, dq_next, rw0_reg, rw0_next;
  logic oe_reg, oe_next, push;
  logic [LANES-1:0] be_reg, be_next;
  logic [LOCK_W-1:0] lock_reg, lock_next;
  logic [STOP_W-1:0] stop_reg, stop_next;
  logic dll_reg, dll_next;
  logic [BUF_W-1:0] buf_mem [BUF_DEPTH];
  logic [0:0] wp_reg, rp_reg;
  logic [1:0] cnt_buf_reg, cnt_buf_next;
  logic adv, pop, room;
  logic [CNT_W-1:0] rd_done;

  assign adv = clk_en & run_reg;
  assign rd_done = dll_reg ? CNT_W'(RD_LAT_DLL + 2) : CNT_W'(RD_LAT_BYP + 2);
  // Back-pressure: a read is only issued with a free buffer slot
  assign room = cnt_buf_reg != 2'(BUF_DEPTH);
  assign cmd_ready = adv && st_reg == B2S_IDLE && !kp_reg && ld_n_reg &&
                     !stop_req && (cmd_write || room);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    kp_next = kp_reg;
    run_next = run_reg;
    ld_n_next = ld_n_reg;
    rsel_next = rsel_reg;
    a_next = a_reg;
    cnt_next = cnt_reg;
    {wd0_next, wd1_next, be0_next, be1_next} =
      {wd0_reg, wd1_reg, be0_reg, be1_reg};
    dq_next = dq_reg;
    oe_next = oe_reg;
    be_next = be_reg;
    rw0_next = rw0_reg;
    push = 1'b0;
    lock_next = lock_reg;
    stop_next = stop_reg;
    dll_next = dll_reg;
    if (clk_en) begin
      dll_next = dll_enable_in;
      // Clocks stop only with nothing outstanding
      if (stop_req && st_reg != B2S_BUSY && ld_n_reg) begin
        run_next = 1'b0;
      end else if (!stop_req) begin
        run_next = 1'b1;
      end
      if (!run_reg) begin
        if (stop_reg != STOP_W'(DLL_STOP_CYC)) begin
          stop_next = stop_reg + 1'b1;
        end
      end else begin
        stop_next = '0;
      end
      if (stop_next == STOP_W'(DLL_STOP_CYC) ||
          (dll_enable_in && !dll_reg)) begin
        lock_next = '0;
        st_next = B2S_LOCK;
      end
    end
    if (adv) begin
      kp_next = ~kp_reg;
      case (st_reg)
        B2S_LOCK: begin
          if (kp_reg && lock_reg != LOCK_W'(DLL_LOCK_KCYC)) begin
            lock_next = lock_reg + 1'b1;
          end
          if (!dll_reg || lock_reg == LOCK_W'(DLL_LOCK_KCYC)) begin
            st_next = B2S_IDLE;
          end
        end
        B2S_IDLE: begin
          if (cmd_ready && cmd_valid) begin
            ld_n_next = 1'b0;
            rsel_next = ~cmd_write;
            a_next = cmd_addr;
            {wd0_next, wd1_next} = {wr_data0, wr_data1};
            {be0_next, be1_next} = {wr_be0_n, wr_be1_n};
          end else if (kp_reg && !ld_n_reg) begin
            ld_n_next = 1'b1;
            cnt_next = CNT_W'(1);
            st_next = B2S_BUSY;
          end
        end
        B2S_BUSY: begin
          cnt_next = cnt_reg + 1'b1;
          oe_next = 1'b0;
          be_next = BE_NONE;
          if (!rsel_reg && cnt_next == CNT_W'(WR_LAT)) begin
            dq_next = wd0_reg;
            be_next = be0_reg;
            oe_next = 1'b1;
          end else if (!rsel_reg && cnt_next == CNT_W'(WR_LAT + 1)) begin
            dq_next = wd1_reg;
            be_next = be1_reg;
            oe_next = 1'b1;
          end
          if (rsel_reg && cnt_reg == rd_done - 1'b1) begin
            rw0_next = link.dq;
          end
          if ((rsel_reg && cnt_reg == rd_done) ||
              (!rsel_reg && cnt_reg == CNT_W'(WR_LAT + 1))) begin
            push = rsel_reg;
            st_next = B2S_IDLE;
          end
        end
        default: st_next = B2S_LOCK;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Two-entry read buffer
  // ----------------------------------------------------------------
  assign pop = rd_valid && rd_ready;
  // Held low while frozen so that no pop slips through
  assign rd_valid = clk_en && cnt_buf_reg != 2'h0;
  assign rd_data = buf_mem[rp_reg];
  always_comb begin
    cnt_buf_next = cnt_buf_reg;
    if (push && !pop) begin
      cnt_buf_next = cnt_buf_reg + 2'h1;
    end else if (pop && !push) begin
      cnt_buf_next = cnt_buf_reg - 2'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_reg <= B2S_LOCK;
      {kp_reg, run_reg, ld_n_reg, rsel_reg} <= 4'h3;
      a_reg <= ADDR_RST;
      cnt_reg <= '0;
      {wd0_reg, wd1_reg, dq_reg, rw0_reg} <= {4{DQ_RST}};
      {be0_reg, be1_reg, be_reg} <= {3{BE_NONE}};
      oe_reg <= 1'b0;
      lock_reg <= '0;
      stop_reg <= '0;
      dll_reg <= 1'b0;
      {wp_reg, rp_reg} <= 2'h0;
      cnt_buf_reg <= 2'h0;
    end else begin
      st_reg <= st_next;
      {kp_reg, run_reg, ld_n_reg, rsel_reg} <=
        {kp_next, run_next, ld_n_next, rsel_next};
      a_reg <= a_next;
      cnt_reg <= cnt_next;
      {wd0_reg, wd1_reg, dq_reg, rw0_reg} <=
        {wd0_next, wd1_next, dq_next, rw0_next};
      {be0_reg, be1_reg, be_reg} <= {be0_next, be1_next, be_next};
      oe_reg <= oe_next;
      lock_reg <= lock_next;
      stop_reg <= stop_next;
      dll_reg <= dll_next;
      if (push) begin
        buf_mem[wp_reg] <= {link.dq, rw0_reg};
        wp_reg <= ~wp_reg;
      end
      if (pop) begin
        rp_reg <= ~rp_reg;
      end
      cnt_buf_reg <= cnt_buf_next;
    end
  end

  assign link.k_phase = kp_reg;
  assign link.k_run = run_reg;
  assign link.c_tied_high = single_clock;
  assign link.dll_enable = dll_reg;
  assign link.load_strobe_n = ld_n_reg;
  assign link.read_sel = rsel_reg;
  assign link.addr = a_reg;
  assign link.byte_enable_n = be_reg;
  assign link.host_dq = dq_reg;
  assign link.host_dq_oe = oe_reg;
  assign stopped = ~run_reg;
endmodule // b2s_host

//--- verilog/b2s_if.sv
// Link between the memory master and the memory device
`timescale 1ns/1ps
interface b2s_if;
  import b2s_pkg::*;
  logic k_phase;
  logic k_run;
  logic c_tied_high;
  logic dll_enable;
  logic load_strobe_n;
  logic read_sel;
  logic [ADDR_W-1:0] addr;
  logic [LANES-1:0] byte_enable_n;
  logic [DQ_W-1:0] host_dq;
  logic host_dq_oe;
  logic [DQ_W-1:0] dev_dq;
  logic dev_dq_oe;
  logic [DQ_W-1:0] dq;
  assign dq = dev_dq_oe ? dev_dq : (host_dq_oe ? host_dq : DQ_RST);
  modport host (
    output k_phase, k_run, c_tied_high, dll_enable, load_strobe_n,
    output read_sel, addr, byte_enable_n, host_dq, host_dq_oe,
    input dq
  );
  modport dev (
    input k_phase, k_run, c_tied_high, dll_enable, load_strobe_n,
    input read_sel, addr, byte_enable_n, dq,
    output dev_dq, dev_dq_oe
  );
endinterface

//--- verilog/b2s_pkg.sv
// Constants shared by both ends of the two-word burst memory port
package b2s_pkg;
  localparam int ADDR_W = 19;
  localparam int LANE_W = 9;
  localparam int LANES = 4;
  localparam int NARROW_LANES = 2;
  localparam int DQ_W = LANE_W * LANES;
  localparam int MEM_WORDS = 1 << ADDR_W;
  // Half-cycles of K counted from the command edge t
  localparam int RD_LAT_DLL = 3;
  localparam int RD_LAT_BYP = 2;
  localparam int WR_LAT = 8;
  localparam int PIPE_LEN = WR_LAT + 1;
  localparam int CNT_W = 4;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int DLL_STOP_PS = 30000;
  localparam int DLL_STOP_CYC = (DLL_STOP_PS + CLK_PERIOD_PS - 1)
                                / CLK_PERIOD_PS;
  localparam int DLL_LOCK_KCYC = 2048;
  localparam int LOCK_W = 12;
  localparam int STOP_W = 4;
  localparam int BUF_DEPTH = 2;
  localparam int BUF_W = 2 * DQ_W;
  localparam logic [ADDR_W-1:0] ADDR_RST = 19'h00000;
  localparam logic [DQ_W-1:0] DQ_RST = 36'h000000000;
  localparam logic [LANES-1:0] BE_NONE = 4'hf;
  typedef enum logic [2:0] {
    B2S_LOCK = 3'b001,
    B2S_IDLE = 3'b010,
    B2S_BUSY = 3'b100
  } b2s_state_t;
endpackage
